// file: rre_regs.svh
// Constants for the return and rotate execution slice
`ifndef RRE_REGS_SVH
`define RRE_REGS_SVH

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RRE_BYTE_MSB 7
`define RRE_BYTE_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RRE_ACC_RST   8'h00
`define RRE_PC_RST    11'h000
`define RRE_CARRY_RST 1'b0
`define RRE_GIE_RST   1'b0
`define RRE_SP_RST    2'h0

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define RRE_IRQ_VECTOR 11'h004

`endif

// file: rre_pkg.sv
// Types shared by the return and rotate execution slice
`default_nettype none

package rre_pkg;

  // ----------------------------------------------------------------
  // Operations handed over by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RRE_OP_NONE  = 3'b000,
    RRE_OP_CALL  = 3'b001,
    RRE_OP_RETL  = 3'b010,
    RRE_OP_IRET  = 3'b011,
    RRE_OP_MROT  = 3'b100,
    RRE_OP_RLACC = 3'b101,
    RRE_OP_RLCY  = 3'b110
  } rre_op_t;

endpackage : rre_pkg

`default_nettype wire

// file: rre_rot_if.sv
// Carrier between the executor and its rotator
`default_nettype none

interface rre_rot_if;
  logic [7:0] in_byte;
  logic       carry_in;
  logic [7:0] rot_plain;
  logic [7:0] rot_carry;
  logic       carry_out;

  modport exec (output in_byte, output carry_in,
                input rot_plain, input rot_carry, input carry_out);
  modport rot  (input in_byte, input carry_in,
                output rot_plain, output rot_carry, output carry_out);
endinterface : rre_rot_if

`default_nettype wire

// file: rre_rotator.sv
// One-position left rotation, plain and through carry
`include "rre_regs.svh"
`default_nettype none

module rre_rotator (
  rre_rot_if.rot port_rot
);

  // Bit 7 wraps to bit 0
  assign port_rot.rot_plain = {port_rot.in_byte[`RRE_BYTE_MSB - 1:`RRE_BYTE_LSB],
                               port_rot.in_byte[`RRE_BYTE_MSB]};

  assign port_rot.rot_carry = {port_rot.in_byte[`RRE_BYTE_MSB - 1:`RRE_BYTE_LSB],
                               port_rot.carry_in};

  assign port_rot.carry_out = port_rot.in_byte[`RRE_BYTE_MSB];

endmodule : rre_rotator

`default_nettype wire

// file: rre_exec.sv
// Return and rotate execution slice of the core
`include "rre_regs.svh"
`default_nettype none

// Notes on behaviour
// - Return-with-literal pops the PC, loads the literal into ACC and touches no flag.
// - Interrupt-exit with no interrupt pending pops the PC and sets the global interrupt enable, touching no flag.
// - A pending interrupt at interrupt-exit is serviced before the main program resumes.
// - Memory rotate-left moves bit 7 to bit 0, writes back in place and alters no flag.
// - Rotate-left into ACC puts the rotation in ACC, leaves memory and flags alone.
// - Rotate-left via carry treats byte and carry as a nine-bit ring, bit 7 to carry.
// - Rotate-left via carry shifts the previous carry into bit 0.
// - Rotate-left via carry writes the byte back and changes only the carry flag.
module rre_exec #(
  parameter int PC_W    = 11,
  parameter int ADDR_W  = 7,
  parameter int DEPTH   = 4
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              op_valid,
  input  wire logic [2:0]        op_code,
  input  wire logic [7:0]        op_imm,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [PC_W-1:0]   op_target,
  input  wire logic [PC_W-1:0]   op_ret_addr,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              irq_pending,
  output logic [PC_W-1:0]        pc,
  output logic                   pc_load,
  output logic [7:0]             acc,
  output logic                   carry,
  output logic                   gie,
  output logic                   irq_ack,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [7:0]             mem_wdata
);

  localparam int SP_W = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  rre_pkg::rre_op_t op;
  assign op = rre_pkg::rre_op_t'(op_code);

  wire logic is_call  = op_valid && (op == rre_pkg::RRE_OP_CALL);
  wire logic is_retl  = op_valid && (op == rre_pkg::RRE_OP_RETL);
  wire logic is_iret  = op_valid && (op == rre_pkg::RRE_OP_IRET);
  wire logic is_mrot  = op_valid && (op == rre_pkg::RRE_OP_MROT);
  wire logic is_rlacc = op_valid && (op == rre_pkg::RRE_OP_RLACC);
  wire logic is_rlcy  = op_valid && (op == rre_pkg::RRE_OP_RLCY);
  // Codes 0 and 7 decode to nothing; the slice never stalls

  // Pending interrupt diverts the exit straight into the handler
  wire logic iret_divert = is_iret && irq_pending;
  wire logic do_pop      = is_retl || (is_iret && !irq_pending);

  // ----------------------------------------------------------------
  // Rotator
  // ----------------------------------------------------------------
  // No forwarding: a rotate right after a write-back sees the stale byte
  rre_rot_if rot_bus ();
  assign rot_bus.in_byte  = mem_rdata;
  assign rot_bus.carry_in = carry;

  rre_rotator u_rot (
    .port_rot (rot_bus.rot)
  );

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Circular like the real nesting stack: overflow silently overwrites
  // Pop on empty wraps as well; the decoder must not issue one
  logic [PC_W-1:0] stack_mem [DEPTH];
  logic [SP_W-1:0] sp;

  wire logic [SP_W-1:0] sp_dec   = sp - SP_W'(1);
  wire logic [PC_W-1:0] top_addr = stack_mem[sp_dec];

  logic [SP_W-1:0] next_sp;
  always_comb begin
    next_sp = sp;
    if (is_call) begin
      next_sp = sp + SP_W'(1);
    end else if (do_pop) begin
      next_sp = sp_dec;
    end
  end

  always_ff @(posedge clock) begin
    if (is_call) begin
      stack_mem[sp] <= op_ret_addr;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sp <= SP_W'(`RRE_SP_RST);
    end else begin
      sp <= next_sp;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and interrupt enable
  // ----------------------------------------------------------------
  // Fixed vector; a wider PC only pads above it
  wire logic [PC_W-1:0] irq_vec = PC_W'(`RRE_IRQ_VECTOR);
  logic [PC_W-1:0] next_pc;
  logic            next_gie;
  always_comb begin
    next_pc  = pc;
    next_gie = gie;
    if (is_call) begin
      next_pc = op_target;
    end else if (iret_divert) begin
      // Handler first; return address stays stacked
      next_pc  = irq_vec;
      next_gie = 1'b0;
    end else if (is_iret) begin
      next_pc  = top_addr;
      next_gie = 1'b1;
    end else if (is_retl) begin
      next_pc = top_addr;
    end
  end

  // Diverted exit loads the vector, so it counts as a load too
  wire logic next_pc_load = is_call || is_iret || is_retl;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc      <= PC_W'(`RRE_PC_RST);
      pc_load <= 1'b0;
    end else begin
      pc      <= next_pc;
      pc_load <= next_pc_load;
    end
  end

  // Ack for controller
  // Pulse only; clearing the request is the controller's job
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gie     <= `RRE_GIE_RST;
      irq_ack <= 1'b0;
    end else begin
      gie     <= next_gie;
      irq_ack <= iret_divert;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and carry
  // ----------------------------------------------------------------
  logic [7:0] next_acc;
  logic       next_carry;
  always_comb begin
    next_acc   = acc;
    next_carry = carry;
    if (is_retl) begin
      next_acc = op_imm;
    end else if (is_rlacc) begin
      next_acc = rot_bus.rot_plain;
    end else if (is_rlcy) begin
      // Carry is the only flag changed
      next_carry = rot_bus.carry_out;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc <= `RRE_ACC_RST;
    end else begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      carry <= `RRE_CARRY_RST;
    end else begin
      carry <= next_carry;
    end
  end

  // ----------------------------------------------------------------
  // Data memory write-back
  // ----------------------------------------------------------------
  // In-place write of plain rotation, or of the through-carry rotation for rotate-left via carry
  wire logic       next_mem_we    = is_mrot || is_rlcy;
  wire logic [7:0] next_mem_wdata = is_rlcy ? rot_bus.rot_carry : rot_bus.rot_plain;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_we <= 1'b0;
    end else begin
      mem_we <= next_mem_we;
    end
  end

  // Address and data follow every cycle; only mem_we qualifies them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_addr  <= '0;
      mem_wdata <= 8'h00;
    end else begin
      mem_addr  <= op_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

endmodule : rre_exec

`default_nettype wire

// file: rre_exec_sva.sv
// Checker for the return and rotate slice
`include "rre_regs.svh"
`default_nettype none
module rre_exec_sva #(
  parameter int PC_W   = 11,
  parameter int ADDR_W = 7
) (
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              op_valid,
  input wire logic [2:0]        op_code,
  input wire logic [7:0]        op_imm,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [PC_W-1:0]   op_ret_addr,
  input wire logic [7:0]        mem_rdata,
  input wire logic              irq_pending,
  input wire logic [PC_W-1:0]   pc,
  input wire logic              pc_load,
  input wire logic [7:0]        acc,
  input wire logic              carry,
  input wire logic              gie,
  input wire logic              irq_ack,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0]        mem_wdata
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_op(int c);
    op_valid && op_code == c;
  endsequence
  sequence s_flags_kept;
    $stable(carry) && $stable(gie);
  endsequence
  AST_RETL: assert property (s_op(2) |=>
    pc_load && acc == $past(op_imm) ##0 s_flags_kept)
    else $error("return with literal wrong");
  AST_IRET: assert property (s_op(3) && !irq_pending |=>
    pc_load && gie && $stable(carry))
    else $error("interrupt exit wrong");
  AST_IRQ: assert property (s_op(3) && irq_pending |=>
    irq_ack && pc_load && !gie && pc == `RRE_IRQ_VECTOR)
    else $error("pending interrupt not taken");
  AST_MROT: assert property (s_op(4) |=> mem_we && mem_addr == $past(op_addr)
    && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} ##0 s_flags_kept)
    else $error("memory rotate wrong");
  AST_RLACC: assert property (s_op(5) |=> !mem_we
    && acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} ##0 s_flags_kept)
    else $error("rotate into acc wrong");
  AST_RING: assert property (s_op(6) |=> carry == $past(mem_rdata[7]))
    else $error("carry ring wrong");
  AST_CIN: assert property (s_op(6) |=>
    mem_wdata == {$past(mem_rdata[6:0]), $past(carry)})
    else $error("old carry not in bit 0");
  AST_RLCY_WB: assert property (s_op(6) |=> mem_we && $stable(acc) && $stable(gie))
    else $error("carry rotate side effect");
  AST_LIFO: assert property (s_op(1) ##1 s_op(2) |=> pc == $past(op_ret_addr, 2))
    else $error("return address wrong");
endmodule : rre_exec_sva

bind rre_exec rre_exec_sva #(.PC_W(PC_W), .ADDR_W(ADDR_W)) u_sva (
  .clock(clock), .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
  .op_addr(op_addr), .op_ret_addr(op_ret_addr), .mem_rdata(mem_rdata),
  .irq_pending(irq_pending), .pc(pc), .pc_load(pc_load), .acc(acc), .carry(carry),
  .gie(gie), .irq_ack(irq_ack), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
`default_nettype wire

// file: rre_tb.sv
// Self-checking bench for the return and rotate slice
`include "rre_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus, outputs and model state
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        op_valid = 1'b0;
  logic        irq_pending = 1'b0;
  logic [2:0]  op_code = 3'h0;
  logic [7:0]  op_imm = 8'h00;
  logic [7:0]  mem_rdata = 8'h00;
  logic [6:0]  op_addr = 7'h00;
  logic [10:0] op_target = 11'h000;
  logic [10:0] op_ret_addr = 11'h000;
  logic [10:0] pc;
  logic [7:0]  acc, mem_wdata;
  logic [6:0]  mem_addr;
  logic        pc_load, carry, gie, irq_ack, mem_we;
  int          fail_count, checked, m_pc, m_acc, m_c, m_gie, wb, ack, d, c;
  int          st[$];

  always #2 clock = ~clock;

  rre_exec DUT (
    .clock(clock), .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
    .op_addr(op_addr), .op_target(op_target), .op_ret_addr(op_ret_addr),
    .mem_rdata(mem_rdata), .irq_pending(irq_pending), .pc(pc), .pc_load(pc_load),
    .acc(acc), .carry(carry), .gie(gie), .irq_ack(irq_ack), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata));

  task chk(input string n, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task results;
    $display("checked %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // One random op; pops only with stack entries held, pushes only with room
  task step;
    op_valid = ($urandom % 8) != 0;
    c = $urandom % 8;
    if ((c == 2 || c == 3) && st.size() == 0) c = 1;
    if (c == 1 && st.size() == 4) c = 2;
    op_code = 3'(c);
    op_imm = 8'($urandom);
    mem_rdata = 8'($urandom);
    op_addr = 7'($urandom);
    op_target = 11'($urandom);
    op_ret_addr = 11'($urandom);
    irq_pending = ($urandom % 3) == 0;
    d = mem_rdata;
    ack = 0;
    if (!op_valid) c = 0;
    if (c == 1) begin
      st.push_back(op_ret_addr);
      m_pc = op_target;
    end
    if (c == 3 && irq_pending) begin
      m_pc = `RRE_IRQ_VECTOR;
      m_gie = 0;
      ack = 1;
    end else if (c == 2 || c == 3) begin
      m_pc = st.pop_back();
      m_acc = (c == 2) ? op_imm : m_acc;
      m_gie = (c == 3) ? 1 : m_gie;
    end
    wb = (c == 4 || c == 6) ? ((d << 1) | (c == 4 ? d >> 7 : m_c)) & 255 : -1;
    if (c == 5) m_acc = ((d << 1) | (d >> 7)) & 255;
    if (c == 6) m_c = d >> 7;
    @(posedge clock);
    #1;
    chk("pc", pc, 11'(m_pc));
    chk("pc_load", pc_load, 11'(c >= 1 && c <= 3));
    chk("acc", acc, 11'(m_acc));
    chk("carry", carry, 11'(m_c));
    chk("gie", gie, 11'(m_gie));
    chk("irq_ack", irq_ack, 11'(ack));
    chk("mem_we", mem_we, 11'(wb >= 0));
    chk("mem_addr", mem_addr, 11'(op_addr));
    if (wb >= 0) chk("mem_wdata", mem_wdata, 11'(wb));
  endtask : step

  initial begin
    c = $urandom(32'h3083);
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    @(posedge clock);
    #1;
    repeat (2000) step();
    results();
  end

  // Watchdog well past the 2000 op cycles
  initial begin
    #20000;
    fail_count++;
    results();
  end
endmodule : tb
`default_nettype wire
